// ===== usf_regs.sv
// Purpose: AHB-Lite register slice: receive count, build options, endpoint FIFO ports.
// Assumes: link side runs on clk_sys and offers 16-bit words with a one-byte flag.
// Notes: Reads take one wait state; writes stall while the target FIFO is full.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.

`timescale 1ns/1ps
`default_nettype none

// Operation
// RL1: Count in bits 12-0, upper bits zero.
// RL2: Count follows FIFO; valid while packet ready.
// RL3: Port write pushes into endpoint transmit FIFO.
// RL4: Port read pops endpoint receive FIFO.
// RL5: Ports a and b behave identically.
// RL6: Bits 7,6 amalgamate/split options, reset 0.
// RL7: Bit 5 byte order, reset 0.
// RL8: Bits 4,3 high-bandwidth iso support, reset 0.
// RL9: Bit 2 resizable FIFO, reset 1.
// RL10: Bit 1 soft attach, reset 1.
// RL11: Bit 0 PHY width, reset 0.
// RL12: Packet ready set on arrival, software clears.
// RL13: Count and options ignore writes.
module usf_regs #(
    parameter logic [7:0] BUILD_OPTS = usf_pkg::CFG_RESET,
    parameter int DEPTH = usf_pkg::FIFO_DEPTH,
    localparam int LW = $clog2(DEPTH) + 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire usf_pkg::usf_rx_word_t rxWord,
    input wire logic rxValid,
    output logic rxReady,
    input wire logic [1:0] txEp,
    input wire logic txTake,
    output logic [15:0] txData,
    output logic txValid,
    output logic [2:0] rxPacketReady
);

    // The byte count must hold two bytes per stored word.
    if (2 * DEPTH >= (1 << usf_pkg::RXCNT_W)) begin : g_badDepth
        $error("usf_regs: DEPTH too large for the byte count");
    end

    // True when a word offset falls on one of the FIFO ports.
    function automatic logic isFifo(input logic [7:0] a);
        return (a >= usf_pkg::OFF_EP0A) && (a <= usf_pkg::OFF_EP2B);
    endfunction : isFifo

    // Endpoint number of a FIFO port; bit 2 picks port a or b and is ignored.
    function automatic logic [1:0] epOf(input logic [7:0] a);
        logic [7:0] d;
        d = a - usf_pkg::OFF_EP0A;
        return d[4:3];
    endfunction : epOf

    usf_pkg::usf_state_t st_q; // Bus slave state.
    logic [7:0] addr_q; // Word-aligned offset of the current data phase.
    logic [31:0] hrdata_q; // Registered read data.
    logic [1:0] epSel_q; // Endpoint whose byte count is shown.
    logic [2:0] pktRdy_q; // Receive packet ready flags, one per endpoint.
    logic [usf_pkg::RXCNT_W-1:0] byteCnt_q [usf_pkg::EP_NUM]; // Bytes held per endpoint.
    logic accept; // A new address phase is taken this cycle.
    logic fifoHit; // Data phase targets a FIFO port.
    logic [1:0] epHit; // Endpoint of that port.
    logic [2:0] txInValid;
    logic [2:0] txInReady;
    logic [2:0] txOutValid;
    logic [2:0] txOutReady;
    logic [15:0] txOutWord [usf_pkg::EP_NUM];
    logic [LW-1:0] txLvl [usf_pkg::EP_NUM];
    logic [2:0] rxInValid;
    logic [2:0] rxInReady;
    logic [2:0] rxOutValid;
    logic [2:0] rxOutReady;
    logic [15:0] rxOutWord [usf_pkg::EP_NUM];
    logic [LW-1:0] rxLvl [usf_pkg::EP_NUM];
    logic rxOneByte [usf_pkg::EP_NUM]; // Whether the head word carries one byte only.

    assign fifoHit = isFifo(addr_q);
    assign epHit = epOf(addr_q);
    assign accept = hsel && htrans[1] && hready;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign rxPacketReady = pktRdy_q;

    // Ready to the bus: writes wait for room, reads insert one wait state.
    always_comb begin
        case (st_q)
            usf_pkg::ST_WR: hreadyout = !(fifoHit && !txInReady[epHit]);
            usf_pkg::ST_RD: hreadyout = 1'b0;
            default: hreadyout = 1'b1;
        endcase
    end

    // Slave state: a new transfer starts only where the bus sees ready.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= usf_pkg::ST_IDLE;
        end else if (st_q == usf_pkg::ST_RD) begin
            st_q <= usf_pkg::ST_RDONE;
        end else if (hreadyout) begin
            if (accept) begin
                st_q <= hwrite ? usf_pkg::ST_WR : usf_pkg::ST_RD;
            end else begin
                st_q <= usf_pkg::ST_IDLE;
            end
        end
    end

    // Address capture; only the low byte is decoded, so upper bits alias.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= 8'h00;
        end else if (hreadyout && accept) begin
            addr_q <= {haddr[7:2], 2'b00};
        end
    end

    // Read data is built in the wait state so that it leaves a flip-flop.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (st_q == usf_pkg::ST_RD) begin
            if (fifoHit) begin
                // An empty FIFO answers zero rather than hanging the bus.
                hrdata_q <= rxOutValid[epHit] ? 32'(rxOutWord[epHit]) : 32'h0000_0000; // [RL4] [RL5]
            end else begin
                case (addr_q)
                    usf_pkg::OFF_RXCNT: hrdata_q <= (epSel_q < 2'd3) ? 32'(byteCnt_q[epSel_q]) : 32'h0000_0000; // [RL1]
                    usf_pkg::OFF_CFG: hrdata_q <= 32'(BUILD_OPTS); // [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]
                    usf_pkg::OFF_CTRL: hrdata_q <= 32'(epSel_q);
                    usf_pkg::OFF_STAT: hrdata_q <= 32'(pktRdy_q);
                    default: hrdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Endpoint select for the count view; the count and option words have no write path.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            epSel_q <= usf_pkg::SEL_RESET;
        end else if (st_q == usf_pkg::ST_WR && addr_q == usf_pkg::OFF_CTRL) begin
            epSel_q <= hwdata[1:0]; // [RL13]
        end
    end

    // Packet ready: set on the last word of a packet, cleared by writing one.
    // A packet ending in the cycle of the clear keeps its flag.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pktRdy_q <= 3'b000;
        end else begin
            for (int e = 0; e < usf_pkg::EP_NUM; e++) begin
                if (rxInValid[e] && rxInReady[e] && rxWord.last) begin
                    pktRdy_q[e] <= 1'b1; // [RL12]
                end else if (st_q == usf_pkg::ST_WR && addr_q == usf_pkg::OFF_STAT && hwdata[e]) begin
                    pktRdy_q[e] <= 1'b0; // [RL12]
                end
            end
        end
    end

    // Byte counts follow every push and pop, so they are live while data moves.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int e = 0; e < usf_pkg::EP_NUM; e++) begin
                byteCnt_q[e] <= '0;
            end
        end else begin
            for (int e = 0; e < usf_pkg::EP_NUM; e++) begin
                byteCnt_q[e] <= byteCnt_q[e]
                    + ((rxInValid[e] && rxInReady[e]) ? (rxWord.oneByte ? usf_pkg::BYTES_HALF : usf_pkg::BYTES_FULL) : '0)
                    - ((rxOutValid[e] && rxOutReady[e]) ? (rxOneByte[e] ? usf_pkg::BYTES_HALF : usf_pkg::BYTES_FULL) : '0); // [RL2]
            end
        end
    end

    // Link side: route the offered word to its endpoint; words for absent endpoints are swallowed.
    assign rxReady = (rxWord.ep < 2'd3) ? rxInReady[rxWord.ep] : 1'b1;
    assign txData = (txEp < 2'd3) ? txOutWord[txEp] : 16'h0000;
    assign txValid = (txEp < 2'd3) ? txOutValid[txEp] : 1'b0;

    // One transmit and one receive FIFO per endpoint; ports a and b share them.
    for (genvar e = 0; e < usf_pkg::EP_NUM; e++) begin : g_ep
        logic [16:0] rxHead; // Receive word with its one-byte flag.

        assign txInValid[e] = (st_q == usf_pkg::ST_WR) && fifoHit && (epHit == 2'(e)); // [RL3] [RL5]
        assign txOutReady[e] = txTake && (txEp == 2'(e));
        assign rxInValid[e] = rxValid && (rxWord.ep == 2'(e));
        assign rxOutReady[e] = (st_q == usf_pkg::ST_RD) && fifoHit && (epHit == 2'(e)); // [RL4]
        assign rxOutWord[e] = rxHead[15:0];
        assign rxOneByte[e] = rxHead[16];

        usf_fifo #(
            .WIDTH(16),
            .DEPTH(DEPTH)
        ) u_tx (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .inWord(hwdata[15:0]),
            .inValid(txInValid[e]),
            .inReady(txInReady[e]),
            .outWord(txOutWord[e]),
            .outValid(txOutValid[e]),
            .outReady(txOutReady[e]),
            .level(txLvl[e])
        );

        usf_fifo #(
            .WIDTH(17),
            .DEPTH(DEPTH)
        ) u_rx (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .inWord({rxWord.oneByte, rxWord.data}),
            .inValid(rxInValid[e]),
            .inReady(rxInReady[e]),
            .outWord(rxHead),
            .outValid(rxOutValid[e]),
            .outReady(rxOutReady[e]),
            .level(rxLvl[e])
        );
    end

    // Checks on the register slice.
    property p_cnt_upper;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == usf_pkg::ST_RD && addr_q == usf_pkg::OFF_RXCNT) |=> (hrdata[31:13] == 19'h0_0000);
    endproperty
    a_cnt_upper: assert property (p_cnt_upper) else $error("count upper bits not zero"); // [RL1]

    property p_cnt_empty;
        @(posedge clk_sys) disable iff (!arst_n)
        (rxLvl[0] == '0) |-> (byteCnt_q[0] == '0);
    endproperty
    a_cnt_empty: assert property (p_cnt_empty) else $error("count nonzero with empty FIFO"); // [RL2]

    property p_wr_push;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == usf_pkg::ST_WR && fifoHit && hreadyout && !(txTake && txEp == epHit))
        |=> (txLvl[$past(epHit)] == $past(txLvl[epHit]) + 1'b1);
    endproperty
    a_wr_push: assert property (p_wr_push) else $error("port write did not load FIFO"); // [RL3] [RL5]

    property p_rd_pop;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == usf_pkg::ST_RD && fifoHit && rxOutValid[epHit] && !rxInValid[epHit])
        |=> !hreadyout ##0 (rxLvl[$past(epHit)] == $past(rxLvl[epHit]) - 1'b1) or
            (hreadyout && rxLvl[$past(epHit)] == $past(rxLvl[epHit]) - 1'b1);
    endproperty
    a_rd_pop: assert property (p_rd_pop) else $error("port read did not unload FIFO"); // [RL4]

    property p_rd_wait;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == usf_pkg::ST_RD) |-> !hreadyout ##1 (hreadyout && hrdata[31:16] == 16'h0000);
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answer not one wait state"); // [RL4]

    property p_cfg_read;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == usf_pkg::ST_RD && addr_q == usf_pkg::OFF_CFG) ##1 hreadyout |-> (hrdata == 32'(BUILD_OPTS));
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("option word wrong"); // [RL6] [RL7] [RL8] [RL9] [RL10] [RL11]

    property p_rdy_set;
        @(posedge clk_sys) disable iff (!arst_n)
        (rxValid && rxReady && rxWord.last && rxWord.ep < 2'd3) |=> rxPacketReady[$past(rxWord.ep)];
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("packet ready not set"); // [RL12]

    property p_ro_write;
        @(posedge clk_sys) disable iff (!arst_n)
        (st_q == usf_pkg::ST_WR && (addr_q == usf_pkg::OFF_CFG || addr_q == usf_pkg::OFF_RXCNT))
        |=> $stable(epSel_q) && (rxPacketReady == ($past(rxPacketReady) | rxPacketReady));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write had an effect"); // [RL13]

endmodule : usf_regs

`default_nettype wire

// ===== usf_pkg.sv
// Purpose: Shared constants and types for the endpoint FIFO register slice.
// Assumes: 32-bit AHB-Lite data bus, one register per aligned word.
// Notes: Only the low address byte is decoded.

`default_nettype none

package usf_pkg;

    // Number of endpoints served by the FIFO ports.
    localparam int unsigned EP_NUM = 3;
    // Depth of each endpoint FIFO, in 16-bit words.
    localparam int unsigned FIFO_DEPTH = 32;
    // Width of one FIFO word.
    localparam int unsigned WORD_W = 16;
    // Width of the receive byte count field.
    localparam int unsigned RXCNT_W = 13;

    // Register byte offsets.
    localparam logic [7:0] OFF_RXCNT = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_EP0A = 8'h08;
    localparam logic [7:0] OFF_EP2B = 8'h1C;
    localparam logic [7:0] OFF_CTRL = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h24;

    // Reset value of the build option word: resizable FIFO and soft attach present.
    localparam logic [7:0] CFG_RESET = 8'h06;
    // Reset value of the endpoint select field.
    localparam logic [1:0] SEL_RESET = 2'h0;
    // Byte weights of a full and a half word.
    localparam logic [RXCNT_W-1:0] BYTES_FULL = 13'h0002;
    localparam logic [RXCNT_W-1:0] BYTES_HALF = 13'h0001;

    // One word offered by the USB link side to a receive FIFO.
    typedef struct packed {
        logic [1:0] ep;
        logic [WORD_W-1:0] data;
        logic oneByte;
        logic last;
    } usf_rx_word_t;

    // Bus slave states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WR,
        ST_RD,
        ST_RDONE
    } usf_state_t;

endpackage : usf_pkg

`default_nettype wire

// ===== usf_fifo.sv
// Purpose: Synchronous FIFO used for every endpoint direction.
// Assumes: DEPTH is a power of two, at least two.
// Notes: Valid/ready on both sides; level reports stored words.

`timescale 1ns/1ps
`default_nettype none

module usf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    localparam int PW = $clog2(DEPTH)
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] inWord,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outWord,
    output logic outValid,
    input wire logic outReady,
    output logic [PW:0] level
);

    // Refuse shapes the pointer arithmetic cannot serve.
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_badDepth
        $error("usf_fifo: DEPTH must be a power of two of at least two");
    end

    // Storage; not reset, since stale words are never shown as valid.
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers carry one extra wrap bit to tell full from empty.
    logic [PW:0] wrPtr_q;
    logic [PW:0] rdPtr_q;
    logic push;
    logic pop;

    assign level = wrPtr_q - rdPtr_q;
    assign inReady = (level != (PW+1)'(DEPTH));
    assign outValid = (wrPtr_q != rdPtr_q);
    assign outWord = mem[rdPtr_q[PW-1:0]];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Write side stores the word at the write pointer.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_q[PW-1:0]] <= inWord;
        end
    end

    // Write pointer advances on every accepted word.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_q <= '0;
        end else if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    // Read pointer advances on every word taken away.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdPtr_q <= '0;
        end else if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

endmodule : usf_fifo

`default_nettype wire

// ===== usf_host_model.sv
// Purpose: Behavioural USB host side that feeds receive FIFOs and drains transmit FIFOs.
// Assumes: The link side runs on clk_sys, as the register slice expects.
// Notes: A released word shows its inverse, so a stale value is never mistaken for data.

`timescale 1ns/1ps
`default_nettype none

module usf_host_model (
    input wire logic clk_sys,
    output var usf_pkg::usf_rx_word_t rxWord,
    output logic rxValid,
    input wire logic rxReady,
    output logic [1:0] txEp,
    output logic txTake,
    input wire logic [15:0] txData,
    input wire logic txValid
);
    // Idle state of the link before any traffic.
    initial begin
        rxWord = '0;
        rxValid = 1'b0;
        txEp = 2'h0;
        txTake = 1'b0;
    end

    // Offers one word and holds it until the slice takes it; the last word closes the packet.
    task automatic send(input logic [1:0] ep, input logic [15:0] d, input logic one, input logic last);
        @(posedge clk_sys);
        rxWord <= '{ep: ep, data: d, oneByte: one, last: last};
        rxValid <= 1'b1;
        do @(posedge clk_sys); while (rxReady !== 1'b1);
        rxValid <= 1'b0;
        rxWord <= ~rxWord;
    endtask : send

    // Selects an endpoint and holds the take request; the word is taken at the edge that pops it.
    task automatic take(input logic [1:0] ep, output logic [15:0] d);
        @(posedge clk_sys);
        txEp <= ep;
        txTake <= 1'b1;
        do @(posedge clk_sys); while (txValid !== 1'b1);
        d = txData;
        txTake <= 1'b0;
    endtask : take
endmodule : usf_host_model

`default_nettype wire

// ===== usf_regs_tb.sv
// Purpose: Self-checking bench for the endpoint FIFO register slice.
// Assumes: A single AHB-Lite master, word transfers only, slave always answers OKAY.
// Notes: Expected values are worked out here from the register layout.

`timescale 1ns/1ps
`default_nettype none

module usf_regs_tb;
    logic clk_sys; // System clock, 200 MHz.
    logic arst_n; // Active-low reset.
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic hwrite;
    logic hready, hresp;
    logic [31:0] hrdata;
    usf_pkg::usf_rx_word_t rxWord;
    logic rxValid, rxReady, txTake, txValid;
    logic [1:0] txEp;
    logic [15:0] txData, got;
    logic [2:0] rxPacketReady;
    int fails = 0; // Mismatches seen.
    int checks_done = 0; // Comparisons made.
    logic [7:0] portAddr;

    // The one slave's hreadyout is the bus's hready.
    usf_regs usf_regs_i (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady), .txEp(txEp),
        .txTake(txTake), .txData(txData), .txValid(txValid), .rxPacketReady(rxPacketReady));

    usf_host_model usf_host_model_i (.clk_sys(clk_sys), .rxWord(rxWord), .rxValid(rxValid),
        .rxReady(rxReady), .txEp(txEp), .txTake(txTake), .txData(txData), .txValid(txValid));

    // Clock generator.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Compares one 32-bit result; four-state equality so an unknown never matches.
    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        checks_done++;
        if (act !== exp) begin
            fails++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask : chk

    // One AHB-Lite transfer; the address phase holds until hready, then the data phase does.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Reads a register and compares it with the expected word.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0000_0000, r);
        chk(exp, r);
        // The slave must always answer OKAY.
        chk(32'h0000_0000, {31'h0000_0000, hresp});
    endtask : rd_chk

    // Writes a register.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    // Watchdog: the tests need a few hundred cycles, so 20000 means a hang.
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        arst_n = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // Build options: only resizable FIFO and soft attach are present.
        rd_chk(usf_pkg::OFF_CFG, 32'h0000_0006);
        rd_chk(usf_pkg::OFF_RXCNT, 32'h0000_0000);
        // Read-only words must ignore writes of all ones.
        wr(usf_pkg::OFF_CFG, 32'hFFFF_FFFF);
        wr(usf_pkg::OFF_RXCNT, 32'hFFFF_FFFF);
        rd_chk(usf_pkg::OFF_CFG, 32'h0000_0006);
        rd_chk(usf_pkg::OFF_RXCNT, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        // Every port of every endpoint loads its endpoint's transmit FIFO, each word taken before the next write.
        for (int e = 0; e < 3; e++) begin
            for (int p = 0; p < 2; p++) begin
                portAddr = usf_pkg::OFF_EP0A + 8'(8 * e + 4 * p);
                wr(portAddr, {16'hFFFF, 8'hC0, 4'(e), 4'(p)});
                usf_host_model_i.take(2'(e), got);
                chk({24'h00_00C0, 4'(e), 4'(p)}, {16'h0000, got});
            end
        end
        // A three-byte packet per endpoint is counted, unloaded through both ports and released.
        for (int e = 0; e < 3; e++) begin
            usf_host_model_i.send(2'(e), {12'hA50, 4'(e)}, 1'b0, 1'b0);
            usf_host_model_i.send(2'(e), 16'h005A, 1'b1, 1'b1);
            @(posedge clk_sys);
            chk(32'(3'b001 << e), {29'h0, rxPacketReady});
            rd_chk(usf_pkg::OFF_STAT, 32'(3'b001 << e));
            wr(usf_pkg::OFF_CTRL, 32'(e));
            rd_chk(usf_pkg::OFF_RXCNT, 32'h0000_0003);
            portAddr = usf_pkg::OFF_EP0A + 8'(8 * e);
            rd_chk(portAddr, {16'h0000, 12'hA50, 4'(e)});
            rd_chk(usf_pkg::OFF_RXCNT, 32'h0000_0001);
            rd_chk(portAddr + 8'h04, 32'h0000_005A);
            rd_chk(usf_pkg::OFF_RXCNT, 32'h0000_0000);
            rd_chk(portAddr, 32'h0000_0000);
            wr(usf_pkg::OFF_STAT, 32'(3'b001 << e));
            rd_chk(usf_pkg::OFF_STAT, 32'h0000_0000);
        end
        tally_and_finish();
    end
endmodule : usf_regs_tb

`default_nettype wire
